/* File: rtl/rps_pkg.sv */
// Package for the remappable pin select block: register indices, field layout,
// reset values and pin-count constants.
// Assumes a 16-bit register port with word indices; route, interface, top, checker and bench import it.
package rps_pkg;
   // Data and field geometry
   localparam int RPS_DATA_W = 16;
   localparam int RPS_ADDR_W = 4;
   localparam int RPS_SEL_W = 6;
   localparam int RPS_LO_POS = 0;
   localparam int RPS_HI_POS = 8;
   // Pad counts: selector codes reach 64 pads, function codes 64 functions
   localparam int RPS_NUM_PINS = 64;
   localparam int RPS_NUM_FUNCS = 64;
   // Register indices
   localparam logic [3:0] RPS_IDX_UART2 = 4'h0;
   localparam logic [3:0] RPS_IDX_SPI1_CD = 4'h1;
   localparam logic [3:0] RPS_IDX_U3CTS_SPI1SS = 4'h2;
   localparam logic [3:0] RPS_IDX_SPI2_CD = 4'h3;
   localparam logic [3:0] RPS_IDX_SPI2_SS = 4'h4;
   localparam logic [3:0] RPS_IDX_UART4 = 4'h5;
   localparam logic [3:0] RPS_IDX_SPI3_CD = 4'h6;
   localparam logic [3:0] RPS_IDX_SPI3_SS = 4'h7;
   localparam logic [3:0] RPS_IDX_OUT_MAP = 4'h8;
   // Reset values of the selector and output-map fields
   localparam logic [5:0] RPS_SEL_RESET = 6'h3F;
   localparam logic [5:0] RPS_FUNC_RESET = 6'h00;
   // Type of one 6-bit selector field, used by the route, interface and top files
   typedef logic [5:0] rps_sel_t;
endpackage

/* File: rtl/rps_route.sv */
// Routing module: picks one synchronised pad per peripheral input and one
// function per output pad. Assumes pad inputs already synchronised upstream.
`timescale 1ns/1ps
module rps_route (
   // Selector fields
   rps_route_if.route sel,
   // Pad and function levels
   input wire logic [rps_pkg::RPS_NUM_PINS-1:0] pad_level,
   input wire logic [rps_pkg::RPS_NUM_FUNCS-1:0] func_out,
   // Routed results
   output logic [13:0] periph_in,
   output logic [1:0] pin_out
);
   import rps_pkg::*;

   // Pure index lookup; an all-ones code picks the top pad, as after reset
   function automatic logic pick(input logic [63:0] vec, input rps_sel_t idx);
      pick = vec[idx];
   endfunction

   // Combinational routing so a new selector takes effect the cycle after write
   always_comb begin
      for (int i = 0; i < 14; i++) begin
         periph_in[i] = pick(pad_level, sel.in_sel[i]);
      end
      // Function 0 means no peripheral: pad is driven low
      pin_out[0] = (sel.pin0_output_func == RPS_FUNC_RESET) ? 1'b0 : pick(func_out, sel.pin0_output_func);
      pin_out[1] = (sel.pin1_output_func == RPS_FUNC_RESET) ? 1'b0 : pick(func_out, sel.pin1_output_func);
   end
endmodule

/* File: rtl/rps_route_if.sv */
// Interface carrying the live selector fields from the register file to the
// routing module. Assumes one clock; fields are plain register outputs.
`timescale 1ns/1ps
interface rps_route_if;
   import rps_pkg::*;
   rps_sel_t in_sel [14];
   rps_sel_t pin0_output_func;
   rps_sel_t pin1_output_func;
   modport regs (output in_sel, output pin0_output_func, output pin1_output_func);
   modport route (input in_sel, input pin0_output_func, input pin1_output_func);
endinterface

/* File: rtl/rps_top.sv */
// Remappable pin select: selector register file, pad synchronisers and the
// routing module for UART2/3/4 and SPI1/2/3 inputs and output pads 0 and 1.
// Assumes pads are asynchronous, peripherals run on core_clk, simple reg port.
//
// Summary of operation
// - UART2 receive from bits 5-0, clear-to-send from bits 13-8.
// - SPI1 clock from bits 13-8, data input from bits 5-0.
// - SPI1 slave select from bits 5-0, UART3 clear-to-send from 13-8.
// - SPI2 clock from bits 13-8, data input from bits 5-0.
// - SPI2 slave select from bits 5-0; bits 15-6 have no function.
// - UART4 receive from bits 5-0, clear-to-send from bits 13-8.
// - SPI3 clock from bits 13-8, data input from bits 5-0.
// - SPI3 slave select from bits 5-0; bits 15-6 unused.
// - Selector bits are read/write and reset to all ones.
// - Bits 15-14 and 7-6 read zero and ignore writes.
// - Pad 1 gets function in bits 13-8, pad 0 function in bits 5-0.
// - Output-map bits are read/write and reset to zero.
`timescale 1ns/1ps
module rps_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [rps_pkg::RPS_ADDR_W-1:0] reg_addr,
   input wire logic [rps_pkg::RPS_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [rps_pkg::RPS_DATA_W-1:0] reg_rdata,
   // Pads: remappable I/O and input-only pins share one index space
   input wire logic [rps_pkg::RPS_NUM_PINS-1:0] remappable_io_pin,
   // Peripheral output functions, index is the function number
   input wire logic [rps_pkg::RPS_NUM_FUNCS-1:0] periph_func_out,
   // Remappable output pads 0 and 1
   output logic pin0_out,
   output logic pin1_out,
   // Peripheral inputs
   output logic uart2_rx_in,
   output logic uart2_cts_in,
   output logic uart3_cts_in,
   output logic uart4_rx_in,
   output logic uart4_cts_in,
   output logic spi1_clock_in,
   output logic spi1_din_in,
   output logic spi1_slave_select_in,
   output logic spi2_clock_in,
   output logic spi2_din_in,
   output logic spi2_slave_select_in,
   output logic spi3_clock_in,
   output logic spi3_din_in,
   output logic spi3_slave_select_in
);
   import rps_pkg::*;

   // Field slots inside the in_sel array
   localparam int F_U2RX = 0;
   localparam int F_U2CTS = 1;
   localparam int F_S1DIN = 2;
   localparam int F_S1CLK = 3;
   localparam int F_S1SS = 4;
   localparam int F_U3CTS = 5;
   localparam int F_S2DIN = 6;
   localparam int F_S2CLK = 7;
   localparam int F_S2SS = 8;
   localparam int F_U4RX = 9;
   localparam int F_U4CTS = 10;
   localparam int F_S3DIN = 11;
   localparam int F_S3CLK = 12;
   localparam int F_S3SS = 13;

   rps_route_if rif ();

   rps_sel_t uart2_rx_pin_sel_q;
   rps_sel_t uart2_cts_pin_sel_q;
   rps_sel_t spi1_din_pin_sel_q;
   rps_sel_t spi1_clk_pin_sel_q;
   rps_sel_t spi1_ss_pin_sel_q;
   rps_sel_t uart3_cts_pin_sel_q;
   rps_sel_t spi2_din_pin_sel_q;
   rps_sel_t spi2_clk_pin_sel_q;
   rps_sel_t spi2_ss_pin_sel_q;
   rps_sel_t uart4_rx_pin_sel_q;
   rps_sel_t uart4_cts_pin_sel_q;
   rps_sel_t spi3_din_pin_sel_q;
   rps_sel_t spi3_clk_pin_sel_q;
   rps_sel_t spi3_ss_pin_sel_q;
   rps_sel_t pin0_output_func_q;
   rps_sel_t pin1_output_func_q;
   logic [RPS_NUM_PINS-1:0] pad_meta_q;
   logic [RPS_NUM_PINS-1:0] pad_sync_q;
   logic [13:0] periph_in;
   logic [1:0] pin_out;
   logic [RPS_DATA_W-1:0] rdata_d;
   logic [RPS_DATA_W-1:0] rdata_q;

   // Field extraction used by every write
   function automatic rps_sel_t lo_f(input logic [15:0] w);
      lo_f = w[RPS_LO_POS +: RPS_SEL_W];
   endfunction
   function automatic rps_sel_t hi_f(input logic [15:0] w);
      hi_f = w[RPS_HI_POS +: RPS_SEL_W];
   endfunction
   // Packs two fields; unimplemented bits 15-14 and 7-6 come back as zero
   function automatic logic [15:0] pack_f(input rps_sel_t hi, input rps_sel_t lo);
      pack_f = {2'h0, hi, 2'h0, lo};
   endfunction

   // only bits 13-8 and 5-0 are stored
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         uart2_rx_pin_sel_q <= RPS_SEL_RESET;
         uart2_cts_pin_sel_q <= RPS_SEL_RESET;
         spi1_din_pin_sel_q <= RPS_SEL_RESET;
         spi1_clk_pin_sel_q <= RPS_SEL_RESET;
         spi1_ss_pin_sel_q <= RPS_SEL_RESET;
         uart3_cts_pin_sel_q <= RPS_SEL_RESET;
         spi2_din_pin_sel_q <= RPS_SEL_RESET;
         spi2_clk_pin_sel_q <= RPS_SEL_RESET;
         spi2_ss_pin_sel_q <= RPS_SEL_RESET;
         uart4_rx_pin_sel_q <= RPS_SEL_RESET;
         uart4_cts_pin_sel_q <= RPS_SEL_RESET;
         spi3_din_pin_sel_q <= RPS_SEL_RESET;
         spi3_clk_pin_sel_q <= RPS_SEL_RESET;
         spi3_ss_pin_sel_q <= RPS_SEL_RESET;
      end else if (reg_wr) begin
         unique case (reg_addr)
            RPS_IDX_UART2: begin
               uart2_rx_pin_sel_q <= lo_f(reg_wdata);
               uart2_cts_pin_sel_q <= hi_f(reg_wdata);
            end
            RPS_IDX_SPI1_CD: begin
               spi1_din_pin_sel_q <= lo_f(reg_wdata);
               spi1_clk_pin_sel_q <= hi_f(reg_wdata);
            end
            RPS_IDX_U3CTS_SPI1SS: begin
               spi1_ss_pin_sel_q <= lo_f(reg_wdata);
               uart3_cts_pin_sel_q <= hi_f(reg_wdata);
            end
            RPS_IDX_SPI2_CD: begin
               spi2_din_pin_sel_q <= lo_f(reg_wdata);
               spi2_clk_pin_sel_q <= hi_f(reg_wdata);
            end
            RPS_IDX_SPI2_SS: begin
               spi2_ss_pin_sel_q <= lo_f(reg_wdata);
            end
            RPS_IDX_UART4: begin
               uart4_rx_pin_sel_q <= lo_f(reg_wdata);
               uart4_cts_pin_sel_q <= hi_f(reg_wdata);
            end
            RPS_IDX_SPI3_CD: begin
               spi3_din_pin_sel_q <= lo_f(reg_wdata);
               spi3_clk_pin_sel_q <= hi_f(reg_wdata);
            end
            RPS_IDX_SPI3_SS: begin
               spi3_ss_pin_sel_q <= lo_f(reg_wdata);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin0_output_func_q <= RPS_FUNC_RESET;
         pin1_output_func_q <= RPS_FUNC_RESET;
      end else if (reg_wr && reg_addr == RPS_IDX_OUT_MAP) begin
         pin0_output_func_q <= lo_f(reg_wdata);
         pin1_output_func_q <= hi_f(reg_wdata);
      end
   end

   // Read mux; unmapped indices answer zero
   always_comb begin
      unique case (reg_addr)
         RPS_IDX_UART2: rdata_d = pack_f(uart2_cts_pin_sel_q, uart2_rx_pin_sel_q);
         RPS_IDX_SPI1_CD: rdata_d = pack_f(spi1_clk_pin_sel_q, spi1_din_pin_sel_q);
         RPS_IDX_U3CTS_SPI1SS: rdata_d = pack_f(uart3_cts_pin_sel_q, spi1_ss_pin_sel_q);
         RPS_IDX_SPI2_CD: rdata_d = pack_f(spi2_clk_pin_sel_q, spi2_din_pin_sel_q);
         RPS_IDX_SPI2_SS: rdata_d = pack_f(6'h00, spi2_ss_pin_sel_q);
         RPS_IDX_UART4: rdata_d = pack_f(uart4_cts_pin_sel_q, uart4_rx_pin_sel_q);
         RPS_IDX_SPI3_CD: rdata_d = pack_f(spi3_clk_pin_sel_q, spi3_din_pin_sel_q);
         RPS_IDX_SPI3_SS: rdata_d = pack_f(6'h00, spi3_ss_pin_sel_q);
         RPS_IDX_OUT_MAP: rdata_d = pack_f(pin1_output_func_q, pin0_output_func_q);
         default: rdata_d = 16'h0000;
      endcase
   end

   // Read data held only in the cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 16'h0000;
      end
   end
   assign reg_rdata = rdata_q;

   // Pad synchronisers: pads are asynchronous to core_clk
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_meta_q <= '0;
         pad_sync_q <= '0;
      end else begin
         pad_meta_q <= remappable_io_pin;
         pad_sync_q <= pad_meta_q;
      end
   end

   assign rif.in_sel[F_U2RX] = uart2_rx_pin_sel_q;
   assign rif.in_sel[F_U2CTS] = uart2_cts_pin_sel_q;
   assign rif.in_sel[F_S1DIN] = spi1_din_pin_sel_q;
   assign rif.in_sel[F_S1CLK] = spi1_clk_pin_sel_q;
   assign rif.in_sel[F_S1SS] = spi1_ss_pin_sel_q;
   assign rif.in_sel[F_U3CTS] = uart3_cts_pin_sel_q;
   assign rif.in_sel[F_S2DIN] = spi2_din_pin_sel_q;
   assign rif.in_sel[F_S2CLK] = spi2_clk_pin_sel_q;
   assign rif.in_sel[F_S2SS] = spi2_ss_pin_sel_q;
   assign rif.in_sel[F_U4RX] = uart4_rx_pin_sel_q;
   assign rif.in_sel[F_U4CTS] = uart4_cts_pin_sel_q;
   assign rif.in_sel[F_S3DIN] = spi3_din_pin_sel_q;
   assign rif.in_sel[F_S3CLK] = spi3_clk_pin_sel_q;
   assign rif.in_sel[F_S3SS] = spi3_ss_pin_sel_q;
   assign rif.pin0_output_func = pin0_output_func_q;
   assign rif.pin1_output_func = pin1_output_func_q;

   rps_route rps_route_i (
      .sel(rif.route),
      .pad_level(pad_sync_q),
      .func_out(periph_func_out),
      .periph_in(periph_in),
      .pin_out(pin_out)
   );

   assign uart2_rx_in = periph_in[F_U2RX];
   assign uart2_cts_in = periph_in[F_U2CTS];
   assign spi1_din_in = periph_in[F_S1DIN];
   assign spi1_clock_in = periph_in[F_S1CLK];
   assign spi1_slave_select_in = periph_in[F_S1SS];
   assign uart3_cts_in = periph_in[F_U3CTS];
   assign spi2_din_in = periph_in[F_S2DIN];
   assign spi2_clock_in = periph_in[F_S2CLK];
   assign spi2_slave_select_in = periph_in[F_S2SS];
   assign uart4_rx_in = periph_in[F_U4RX];
   assign uart4_cts_in = periph_in[F_U4CTS];
   assign spi3_din_in = periph_in[F_S3DIN];
   assign spi3_clock_in = periph_in[F_S3CLK];
   assign spi3_slave_select_in = periph_in[F_S3SS];
   assign pin0_out = pin_out[0];
   assign pin1_out = pin_out[1];
endmodule

/* File: verif/rps_far_model.sv */
// Far side of the pin select: pads and peripheral output functions.
// Assumes the bench names the wanted levels; they move on the falling edge.
`timescale 1ns/1ps
module rps_far_model (
   // Clock
   input wire logic core_clk,
   // Levels wanted by the bench
   input wire logic [63:0] pad_set,
   input wire logic [63:0] func_set,
   // Pads and peripheral outputs
   output logic [63:0] remappable_io_pin,
   output logic [63:0] periph_func_out
);
   // Pads switch away from the sampling edge, like an unrelated source
   always @(negedge core_clk) remappable_io_pin <= pad_set;
   // Peripheral outputs follow the bench on the same falling edge
   always @(negedge core_clk) periph_func_out <= func_set;
endmodule

/* File: verif/rps_top_assertions.sv */
// Checker for the remappable pin select: mirrors the selectors from the write
// strobe and the pad synchroniser, then ties every routed output to them.
// Assumes it sees only the ports of rps_top; attached by the bind at the foot.
`timescale 1ns/1ps
module rps_top_assertions (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Pads and functions
   input wire logic [63:0] remappable_io_pin,
   input wire logic [63:0] periph_func_out,
   input wire logic pin0_out,
   input wire logic pin1_out,
   // Peripheral inputs
   input wire logic uart2_rx_in,
   input wire logic uart2_cts_in,
   input wire logic uart3_cts_in,
   input wire logic uart4_rx_in,
   input wire logic uart4_cts_in,
   input wire logic spi1_clock_in,
   input wire logic spi1_din_in,
   input wire logic spi1_slave_select_in,
   input wire logic spi2_clock_in,
   input wire logic spi2_din_in,
   input wire logic spi2_slave_select_in,
   input wire logic spi3_clock_in,
   input wire logic spi3_din_in,
   input wire logic spi3_slave_select_in
);
   import rps_pkg::*;
   logic [15:0] sh_q [9];
   logic [63:0] s1_q;
   logic [63:0] s2_q;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // Mirror keeps only implemented bits, so readback compares directly
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 9; i++) begin
            sh_q[i] <= (i == 8) ? 16'h0000 : (i == 4 || i == 7) ? 16'h003F : 16'h3F3F;
         end
      end else if (reg_wr && reg_addr < 4'h9) begin
         sh_q[reg_addr] <= reg_wdata & ((reg_addr == 4'h4 || reg_addr == 4'h7) ? 16'h003F : 16'h3F3F);
      end
   end
   // Two-stage pad mirror, same depth as the design's synchroniser
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 64'h0;
         s2_q <= 64'h0;
      end else begin
         s1_q <= remappable_io_pin;
         s2_q <= s1_q;
      end
   end
   AST_UART2: assert property (uart2_rx_in == s2_q[sh_q[0][5:0]] && uart2_cts_in == s2_q[sh_q[0][13:8]])
      else $error("uart2 inputs misrouted");
   AST_SPI1: assert property (spi1_din_in == s2_q[sh_q[1][5:0]] && spi1_clock_in == s2_q[sh_q[1][13:8]])
      else $error("spi1 clock or data misrouted");
   AST_SS1_CTS3: assert property (spi1_slave_select_in == s2_q[sh_q[2][5:0]] && uart3_cts_in == s2_q[sh_q[2][13:8]])
      else $error("spi1 select or uart3 cts misrouted");
   AST_SPI2: assert property (spi2_din_in == s2_q[sh_q[3][5:0]] && spi2_clock_in == s2_q[sh_q[3][13:8]] && spi2_slave_select_in == s2_q[sh_q[4][5:0]])
      else $error("spi2 inputs misrouted");
   AST_UART4: assert property (uart4_rx_in == s2_q[sh_q[5][5:0]] && uart4_cts_in == s2_q[sh_q[5][13:8]])
      else $error("uart4 inputs misrouted");
   AST_SPI3: assert property (spi3_din_in == s2_q[sh_q[6][5:0]] && spi3_clock_in == s2_q[sh_q[6][13:8]] && spi3_slave_select_in == s2_q[sh_q[7][5:0]])
      else $error("spi3 inputs misrouted");
   AST_PIN_MAP: assert property ({pin1_out, pin0_out} == {(sh_q[8][13:8] != 6'h00) & periph_func_out[sh_q[8][13:8]], (sh_q[8][5:0] != 6'h00) & periph_func_out[sh_q[8][5:0]]})
      else $error("output pad function wrong");
   AST_READBACK: assert property ($past(reg_rd) |-> reg_rdata == ($past(reg_addr) < 4'h9 ? sh_q[$past(reg_addr)] : 16'h0000))
      else $error("read data differs from register");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside answer cycle");
   AST_RSVD: assert property (reg_rdata[15:14] == 2'h0 && reg_rdata[7:6] == 2'h0)
      else $error("unimplemented bits read nonzero");
endmodule
bind rps_top rps_top_assertions rps_top_assertions_i (.*);

/* File: verif/rps_top_test.sv */
// Testbench for the pin select: register table, routing, output map, reset.
// Assumes rps_top, its checker and the far-side model are compiled before it.
`timescale 1ns/1ps
module rps_top_test;
   import rps_pkg::*;
   typedef struct {logic [3:0] a; logic [15:0] w; logic [15:0] e;} rps_row_s;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [63:0] pad_set = 64'h0;
   logic [63:0] func_set = 64'h0;
   logic [63:0] remappable_io_pin, periph_func_out;
   logic [15:0] reg_rdata, rd_v;
   logic pin0_out, pin1_out, uart2_rx_in, uart2_cts_in, uart3_cts_in, uart4_rx_in, uart4_cts_in;
   logic spi1_clock_in, spi1_din_in, spi1_slave_select_in, spi2_clock_in, spi2_din_in, spi2_slave_select_in;
   logic spi3_clock_in, spi3_din_in, spi3_slave_select_in;
   logic [13:0] periph;
   logic [15:0] model_q [9];
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   // Rows: index, written value, value that must read back
   rps_row_s rows [11] = '{'{4'h0, 16'hFFFF, 16'h3F3F}, '{4'h1, 16'h0502, 16'h0502}, '{4'h2, 16'h2A15, 16'h2A15},
      '{4'h3, 16'hC0C0, 16'h0000}, '{4'h4, 16'hFFFF, 16'h003F}, '{4'h5, 16'h0A3E, 16'h0A3E},
      '{4'h6, 16'h1020, 16'h1020}, '{4'h7, 16'h1234, 16'h0034}, '{4'h8, 16'h0201, 16'h0201},
      '{4'h9, 16'h1111, 16'h0000}, '{4'hF, 16'hFFFF, 16'h0000}};
   logic [63:0] pats [3] = '{64'h0123456789ABCDEF, 64'hFEDCBA9876543210, 64'hA5A55A5AC33C0FF0};
   int kreg [14] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 5, 5, 6, 6, 7};
   logic [13:0] khi = 14'h14AA;
   rps_top rps_top_i (.*);
   rps_far_model rps_far_model_i (.core_clk(core_clk), .pad_set(pad_set), .func_set(func_set),
      .remappable_io_pin(remappable_io_pin), .periph_func_out(periph_func_out));
   // Peripheral inputs in register order, low field before high field
   assign periph = {spi3_slave_select_in, spi3_clock_in, spi3_din_in, uart4_cts_in, uart4_rx_in, spi2_slave_select_in,
      spi2_clock_in, spi2_din_in, uart3_cts_in, spi1_slave_select_in, spi1_clock_in, spi1_din_in, uart2_cts_in, uart2_rx_in};
   always #12.5 core_clk = ~core_clk;
   // Cut a hang short well past the expected run length
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   function automatic logic [13:0] route_exp(input logic [63:0] p);
      logic [5:0] s;
      route_exp = 14'h0;
      for (int k = 0; k < 14; k++) begin
         s = khi[k] ? model_q[kreg[k]][13:8] : model_q[kreg[k]][5:0];
         route_exp[k] = p[s];
      end
   endfunction
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rd_v);
         check(rd_v, rows[i].e);
         if (rows[i].a < 4'h9) model_q[rows[i].a] = rows[i].e;
      end
      // Each pad pattern must appear on the selected peripheral inputs
      foreach (pats[i]) begin
         @(posedge core_clk);
         pad_set <= pats[i];
         tick(4);
         check({2'h0, periph}, {2'h0, route_exp(pats[i])});
      end
      $display("table and routing done");
      // Pad 1 takes function 2, pad 0 function 1; code zero drives low
      @(posedge core_clk);
      func_set <= 64'h5;
      tick(2);
      check({14'h0, pin1_out, pin0_out}, 16'h0002);
      func_set <= 64'h3;
      tick(2);
      check({14'h0, pin1_out, pin0_out}, 16'h0001);
      wr(4'h8, 16'h0000);
      func_set <= 64'h7;
      tick(2);
      check({14'h0, pin1_out, pin0_out}, 16'h0000);
      $display("output map done");
      // Read straight after write; routing moves in the next cycle
      pad_set <= 64'h8;
      repeat (3) @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= 4'h0;
      reg_wdata <= 16'h3F03;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      #1 check({15'h0, uart2_rx_in}, 16'h0001);
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, 16'h3F03);
      $display("back to back done");
      // Second reset mid-run restores every field
      @(posedge core_clk);
      rst_n <= 1'b0;
      pad_set <= 64'h8000000000000000;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 9; a++) begin
         rd(a[3:0], rd_v);
         check(rd_v, a == 8 ? 16'h0000 : (a == 4 || a == 7) ? 16'h003F : 16'h3F3F);
      end
      check({2'h0, periph}, 16'h3FFF);
      $display("reset done");
      end_sim();
   end
endmodule
